// ===== flash_cmd_pkg.sv
package flash_cmd_pkg;
  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] REG_CMD   = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_DATA  = 8'h08;
  localparam logic [7:0] REG_LOCK  = 8'h0c;
  localparam logic [7:0] REG_FAULT = 8'h10;
  localparam logic [7:0] REG_STATE = 8'h14;

  // command codes on the flash data bus, low byte
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND     = 8'hb0;
  localparam logic [7:0] CMD_READ        = 8'hff;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_CLEAR       = 8'h50;
  localparam logic [7:0] CMD_PROG_SETUP  = 8'h40;
  localparam logic [7:0] CMD_PR_SETUP    = 8'hc0;

  // status word bit positions
  localparam int SB_READY   = 7;
  localparam int SB_SUSP    = 6;
  localparam int SB_ERASE   = 5;
  localparam int SB_PROG    = 4;
  localparam int SB_SUPPLY  = 3;
  localparam int SB_LOCKED  = 1;
  localparam logic [7:0] ERR_MASK = 8'h3a;

  // fault register fields
  localparam int FB_SUPPLY_LOW = 0;
  localparam int FB_ERASE_FAIL = 1;
  localparam int FB_PROG_FAIL  = 2;
  localparam logic [2:0] FAULT_RST = 3'h0;

  // flash address layout
  localparam int ADDR_W     = 23;
  localparam int SECTOR_LSB = 15;
  localparam int LOCK_W     = 16;
  localparam logic [15:0] LOCK_RST = 16'h0000;

  // one-time protection words, factory part is pre-locked
  localparam logic [ADDR_W-1:0] OTP_FIRST   = 23'h000081;
  localparam logic [ADDR_W-1:0] OTP_LAST    = 23'h000088;
  localparam logic [ADDR_W-1:0] OTP_FACTORY = 23'h000084;
  localparam int OTP_WORDS = 8;
  localparam logic [15:0] OTP_RST    = 16'hffff;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // timing
  localparam int CLK_KHZ        = 20000;
  localparam int ERASE_TIME_MS  = 800;
  localparam int PROG_TIME_US   = 10;
  localparam int ERASE_CYCLES_DEF = ERASE_TIME_MS * CLK_KHZ;
  localparam int PROG_CYCLES_DEF  = (PROG_TIME_US * CLK_KHZ) / 1000;
  localparam int TIMER_W = 24;

  typedef enum logic [6:0] {
    ST_IDLE        = 7'b0000001,
    ST_ERS_SETUP   = 7'b0000010,
    ST_ERASING     = 7'b0000100,
    ST_SUSP        = 7'b0001000,
    ST_PR_SETUP    = 7'b0010000,
    ST_PROG_SETUP  = 7'b0100000,
    ST_PROGRAMMING = 7'b1000000
  } seq_state_t;
endpackage

// ===== op_timer.sv
`timescale 1ns/100ps
module op_timer #(
  parameter int W = 24
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         run,
  output logic              done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_val;
    end else if (run && cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  // count freezes while run is low, which is how a suspend holds its place
  assign done = run && !load && cnt_r == W'(1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ===== flash_cmd_status.sv
// Function
// - status word returned while busy, refreshed per read; ready bit 1 ready, 0 busy
// - command sequence error sets both program-fail and erase-fail bits
// - failed sector erase sets erase-fail bit alone
// - erase of a locked sector aborts and sets locked-abort bit
// - protection program outcome: supply 0,1,1; failure 0,0,1; locked 1,0,1
// - no erase starts while locked-abort or supply bit is still set
// - error bits stay until clear-status; nothing else clears them
// - while suspended, reads and programs to other sectors are served
`timescale 1ns/100ps
module flash_cmd_status
  import flash_cmd_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = flash_cmd_pkg::ERASE_CYCLES_DEF,
  parameter int unsigned PROG_CYCLES  = flash_cmd_pkg::PROG_CYCLES_DEF
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  import flash_cmd_pkg::*;

  // bus slave state
  logic                 wr_pend_r;
  logic                 wr_pend_nxt;
  logic [7:0]           wr_addr_r;
  logic [7:0]           wr_addr_nxt;
  logic [31:0]          rdata_r;
  logic [31:0]          rdata_nxt;
  logic [ADDR_W-1:0]    addr_r;
  logic [ADDR_W-1:0]    addr_nxt;
  logic [LOCK_W-1:0]    lock_r;
  logic [LOCK_W-1:0]    lock_nxt;
  logic [2:0]           fault_r;
  logic [2:0]           fault_nxt;

  // sequencer state
  seq_state_t           state_r;
  seq_state_t           state_nxt;
  logic [7:0]           flags_r;
  logic [7:0]           flags_nxt;
  logic                 mode_status_r;
  logic                 mode_status_nxt;
  logic                 erase_susp_r;
  logic                 erase_susp_nxt;
  logic [ADDR_W-1:SECTOR_LSB] sector_r;
  logic [ADDR_W-1:SECTOR_LSB] sector_nxt;
  logic [15:0]          otp_r [OTP_WORDS];
  logic [15:0]          otp_nxt [OTP_WORDS];

  logic                 addr_take;
  logic                 cmd_wr;
  logic [7:0]           code;
  logic [15:0]          word;
  logic                 same_sector;
  logic                 sector_locked;
  logic                 otp_in_range;
  logic                 otp_factory;
  logic [2:0]           otp_idx;
  logic [2:0]           rd_idx;
  logic [7:0]           status_word;
  logic [15:0]          array_word;
  logic                 ers_load;
  logic                 ers_done;
  logic                 prog_load;
  logic                 prog_done;
  logic [7:0]           err_set;
  logic [7:0]           err_clr;
  seq_state_t           ret_state;

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  assign addr_take = hsel && hready && htrans[1];
  assign cmd_wr    = wr_pend_r && wr_addr_r == REG_CMD;
  assign code      = hwdata[7:0];
  assign word      = hwdata[15:0];

  assign same_sector   = addr_r[ADDR_W-1:SECTOR_LSB] == sector_r;
  assign sector_locked = lock_r[addr_r[SECTOR_LSB+3:SECTOR_LSB]];
  assign otp_in_range  = addr_r >= OTP_FIRST && addr_r <= OTP_LAST;
  assign otp_factory   = addr_r <= OTP_FACTORY;
  assign otp_idx       = 3'(addr_r - OTP_FIRST);
  assign rd_idx        = otp_idx;
  assign ret_state     = erase_susp_r ? ST_SUSP : ST_IDLE;

  // live status; the read itself is the output-enable toggle that refreshes it
  always_comb begin
    status_word             = flags_r & ERR_MASK;
    status_word[SB_READY]   = !(state_r inside {ST_ERASING, ST_PROGRAMMING});
    status_word[SB_SUSP]    = erase_susp_r;
  end

  // array contents are not modelled beyond the protection words
  assign array_word = otp_in_range ? otp_r[rd_idx] : ERASED_WORD;

  always_comb begin
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    rdata_nxt   = rdata_r;
    addr_nxt    = addr_r;
    lock_nxt    = lock_r;
    fault_nxt   = fault_r;
    if (addr_take) begin
      wr_pend_nxt = hwrite;
      wr_addr_nxt = haddr[7:0];
      if (!hwrite) begin
        unique case (haddr[7:0])
          REG_ADDR:  rdata_nxt = {9'h000, addr_r};
          REG_DATA:  rdata_nxt = mode_status_r ? {24'h000000, status_word}
                                               : {16'h0000, array_word};
          REG_LOCK:  rdata_nxt = {16'h0000, lock_r};
          REG_FAULT: rdata_nxt = {29'h00000000, fault_r};
          REG_STATE: rdata_nxt = {16'h0000, status_word, mode_status_r, state_r};
          default:   rdata_nxt = 32'h00000000;
        endcase
      end
    end
    if (wr_pend_r) begin
      unique case (wr_addr_r)
        REG_ADDR:  addr_nxt  = hwdata[ADDR_W-1:0];
        REG_LOCK:  lock_nxt  = hwdata[LOCK_W-1:0];
        REG_FAULT: fault_nxt = hwdata[2:0];
        default:   ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h00000000;
      addr_r    <= '0;
      lock_r    <= LOCK_RST;
      fault_r   <= FAULT_RST;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r   <= rdata_nxt;
      addr_r    <= addr_nxt;
      lock_r    <= lock_nxt;
      fault_r   <= fault_nxt;
    end
  end

  always_comb begin
    state_nxt       = state_r;
    mode_status_nxt = mode_status_r;
    erase_susp_nxt  = erase_susp_r;
    sector_nxt      = sector_r;
    otp_nxt         = otp_r;
    ers_load        = 1'b0;
    prog_load       = 1'b0;
    err_set         = 8'h00;
    err_clr         = 8'h00;
    unique case (state_r)
      ST_IDLE, ST_SUSP: begin
        if (cmd_wr) begin
          unique case (code)
            CMD_READ:   mode_status_nxt = 1'b0;
            CMD_STATUS: mode_status_nxt = 1'b1;
            CMD_CLEAR:  err_clr = ERR_MASK;
            CMD_ERASE_SETUP: begin
              // a second erase may not start inside a suspend
              if (state_r == ST_IDLE) begin
                state_nxt       = ST_ERS_SETUP;
                sector_nxt      = addr_r[ADDR_W-1:SECTOR_LSB];
                mode_status_nxt = 1'b1;
              end
            end
            CMD_PROG_SETUP: begin
              state_nxt       = ST_PROG_SETUP;
              mode_status_nxt = 1'b1;
            end
            CMD_PR_SETUP: begin
              if (state_r == ST_IDLE) begin
                state_nxt       = ST_PR_SETUP;
                mode_status_nxt = 1'b1;
              end
            end
            CMD_CONFIRM: begin
              if (state_r == ST_SUSP) begin
                state_nxt       = ST_ERASING;
                erase_susp_nxt  = 1'b0;
                mode_status_nxt = 1'b1;
              end
            end
            default: ;
          endcase
        end
      end
      ST_ERS_SETUP: begin
        if (cmd_wr) begin
          state_nxt = ST_IDLE;
          if (code != CMD_CONFIRM || !same_sector) begin
            err_set[SB_PROG]  = 1'b1;
            err_set[SB_ERASE] = 1'b1;
          end else if (flags_r[SB_LOCKED] || flags_r[SB_SUPPLY]) begin
            state_nxt = ST_IDLE;
          end else if (sector_locked) begin
            err_set[SB_LOCKED] = 1'b1;
          end else if (fault_r[FB_SUPPLY_LOW]) begin
            err_set[SB_SUPPLY] = 1'b1;
          end else begin
            state_nxt = ST_ERASING;
            ers_load  = 1'b1;
          end
        end
      end
      ST_ERASING: begin
        // completion beats a suspend arriving in the same cycle
        if (ers_done) begin
          state_nxt = ST_IDLE;
          err_set[SB_ERASE] = fault_r[FB_ERASE_FAIL];
        end else if (cmd_wr && code == CMD_SUSPEND) begin
          state_nxt       = ST_SUSP;
          erase_susp_nxt  = 1'b1;
          mode_status_nxt = 1'b1;
        end else if (cmd_wr && code == CMD_STATUS) begin
          mode_status_nxt = 1'b1;
        end
      end
      ST_PR_SETUP: begin
        if (cmd_wr) begin
          state_nxt = ST_IDLE;
          if (!otp_in_range) begin
            err_set[SB_PROG] = 1'b1;
          end else if (otp_factory) begin
            err_set[SB_LOCKED] = 1'b1;
            err_set[SB_PROG]   = 1'b1;
          end else if (fault_r[FB_SUPPLY_LOW]) begin
            err_set[SB_SUPPLY] = 1'b1;
            err_set[SB_PROG]   = 1'b1;
          end else begin
            state_nxt        = ST_PROGRAMMING;
            prog_load        = 1'b1;
            otp_nxt[otp_idx] = otp_r[otp_idx] & word;
          end
        end
      end
      ST_PROG_SETUP: begin
        if (cmd_wr) begin
          state_nxt = ret_state;
          if (erase_susp_r && same_sector) begin
            err_set[SB_PROG] = 1'b1;
          end else if (sector_locked) begin
            err_set[SB_LOCKED] = 1'b1;
            err_set[SB_PROG]   = 1'b1;
          end else if (fault_r[FB_SUPPLY_LOW]) begin
            err_set[SB_SUPPLY] = 1'b1;
            err_set[SB_PROG]   = 1'b1;
          end else begin
            state_nxt = ST_PROGRAMMING;
            prog_load = 1'b1;
          end
        end
      end
      ST_PROGRAMMING: begin
        if (prog_done) begin
          state_nxt = ret_state;
          err_set[SB_PROG] = fault_r[FB_PROG_FAIL];
        end else if (cmd_wr && code == CMD_STATUS) begin
          mode_status_nxt = 1'b1;
        end
      end
    endcase
    // a hardware set wins over a clear in the same cycle
    flags_nxt = (flags_r & ~err_clr) | err_set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r       <= ST_IDLE;
      flags_r       <= 8'h00;
      mode_status_r <= 1'b0;
      erase_susp_r  <= 1'b0;
      sector_r      <= '0;
      for (int i = 0; i < OTP_WORDS; i++) begin
        otp_r[i] <= OTP_RST;
      end
    end else begin
      state_r       <= state_nxt;
      flags_r       <= flags_nxt;
      mode_status_r <= mode_status_nxt;
      erase_susp_r  <= erase_susp_nxt;
      sector_r      <= sector_nxt;
      otp_r         <= otp_nxt;
    end
  end

  // separate timers so a program inside a suspend keeps the erase's place
  op_timer #(
    .W        (TIMER_W)
  ) u_erase_timer (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (ers_load),
    .load_val (TIMER_W'(ERASE_CYCLES)),
    .run      (state_r == ST_ERASING),
    .done     (ers_done)
  );

  op_timer #(
    .W        (TIMER_W)
  ) u_prog_timer (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (prog_load),
    .load_val (TIMER_W'(PROG_CYCLES)),
    .run      (state_r == ST_PROGRAMMING),
    .done     (prog_done)
  );
endmodule

// ===== flash_cmd_status_asserts.sv
`timescale 1ns/100ps
module flash_cmd_status_asserts
  import flash_cmd_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = 20,
  parameter int unsigned PROG_CYCLES  = 5
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       take;
  logic       st_rd_r;
  logic       st_rd_nxt;
  logic       cmd_wr_r;
  logic       cmd_wr_nxt;
  logic [7:0] err_r;
  logic [7:0] err_nxt;
  assign take = hsel && hready && htrans[1];
  // error bits seen on the last state read, forgotten on any clear command
  always_comb begin
    st_rd_nxt = take && !hwrite && (haddr[7:0] == REG_STATE);
    cmd_wr_nxt = take && hwrite && (haddr[7:0] == REG_CMD);
    err_nxt = err_r;
    if (cmd_wr_r && hwdata[7:0] == CMD_CLEAR) begin
      err_nxt = 8'h00;
    end
    if (st_rd_r) begin
      err_nxt = hrdata[15:8] & ERR_MASK;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_rd_r <= 1'b0;
      cmd_wr_r <= 1'b0;
      err_r <= 8'h00;
    end else begin
      st_rd_r <= st_rd_nxt;
      cmd_wr_r <= cmd_wr_nxt;
      err_r <= err_nxt;
    end
  end
  a_bus_answer: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_data_stands: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_ready_busy: assert property (st_rd_r |-> hrdata[15] == !(hrdata[2] || hrdata[6]))
    else $error("ready bit disagrees with state");
  a_susp_flags: assert property (st_rd_r && hrdata[3] |-> hrdata[14] && hrdata[15])
    else $error("suspended state without suspend flag");
  a_state_onehot: assert property (st_rd_r |-> $onehot(hrdata[6:0]))
    else $error("state field not one-hot");
  a_spare_bits: assert property (st_rd_r |-> !hrdata[10] && !hrdata[8] && hrdata[31:16] == 16'h0)
    else $error("unused status bits set");
  a_err_hold: assert property (st_rd_r |-> (hrdata[15:8] & err_r) == err_r)
    else $error("error bit dropped without clear");
  a_cmd_zero: assert property (take && !hwrite && haddr[7:0] == REG_CMD |=> hrdata == 32'h0)
    else $error("command register read not zero");
  c_erasing: cover property (st_rd_r && hrdata[2]);
  c_suspended: cover property (st_rd_r && hrdata[3]);
  c_errors: cover property (st_rd_r && hrdata[13] && hrdata[12]);
endmodule
bind flash_cmd_status flash_cmd_status_asserts #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES (PROG_CYCLES)
) chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

// ===== host_bfm.sv
`timescale 1ns/100ps
module host_bfm (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
  end
  // one single word transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= w ? d : ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
    // released data lines must not look valid
    hwdata <= ~hwdata;
  endtask
endmodule

// ===== flash_cmd_status_tb.sv
`timescale 1ns/100ps
module flash_cmd_status_tb;
  import flash_cmd_pkg::*;
  logic             hclk = 1'b0;
  logic             hresetn = 1'b0;
  wire logic        hsel;
  wire logic        hwrite;
  wire logic        hreadyout;
  wire logic        hresp;
  wire logic [31:0] haddr;
  wire logic [31:0] hwdata;
  wire logic [31:0] hrdata;
  wire logic [1:0]  htrans;
  wire logic [2:0]  hsize;
  int               err_total = 0;
  int               cmp_count = 0;
  logic [31:0]      q;
  always #25 hclk = ~hclk;
  host_bfm host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  flash_cmd_status #(.ERASE_CYCLES(20), .PROG_CYCLES(5)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic op(input logic [22:0] a, input logic [15:0] c);
    wr(REG_ADDR, {9'h0, a});
    wr(REG_CMD, {16'h0, c});
  endtask
  // status byte and state, mode bit masked out
  task automatic st(input logic [15:0] e);
    rd(REG_STATE);
    chk("status_state", {16'h0, e}, q & 32'h0000ff7f);
  endtask
  task automatic idle_wait;
    int n;
    n = 0;
    rd(REG_STATE);
    while (q[15] !== 1'b1 && n < 200) begin
      rd(REG_STATE);
      n++;
    end
    // a poll that runs out counts against the run
    chk("ready_wait", 32'h1, {31'h0, q[15]});
  endtask
  task automatic erase(input logic [22:0] a);
    op(a, CMD_ERASE_SETUP);
    op(a + 23'h5, CMD_CONFIRM);
  endtask
  task automatic t_regs;
    logic [7:0]  ofs[4] = '{REG_ADDR, REG_LOCK, REG_FAULT, 8'h18};
    logic [31:0] msk[4] = '{32'h007fffff, 32'h0000ffff, 32'h7, 32'h0};
    st(16'h8001);
    rd(REG_CMD);
    chk("cmd_read", 32'h0, q);
    for (int i = 0; i < 4; i++) begin
      rd(ofs[i]);
      chk("reset_value", 32'h0, q);
      wr(ofs[i], 32'hffffffff);
      rd(ofs[i]);
      chk("access", msk[i], q);
      wr(ofs[i], 32'h0);
    end
  endtask
  task automatic t_erase;
    erase(23'h018000);
    st(16'h0004);
    idle_wait;
    st(16'h8001);
    rd(REG_DATA);
    chk("status_word", 32'h80, q);
    erase(23'h020000);
    idle_wait;
    op(23'h020000, CMD_READ);
    rd(REG_DATA);
    chk("array_read", 32'hffff, q);
  endtask
  task automatic t_seq;
    op(23'h008000, CMD_ERASE_SETUP);
    op(23'h008000, CMD_PROG_SETUP);
    st(16'hb001);
    op(23'h0, CMD_READ);
    st(16'hb001);
    op(23'h0, CMD_CLEAR);
    st(16'h8001);
    op(23'h008000, CMD_ERASE_SETUP);
    op(23'h010000, CMD_CONFIRM);
    st(16'hb001);
    op(23'h0, CMD_CLEAR);
  endtask
  task automatic t_fault;
    logic [31:0] f[3] = '{32'h2, 32'h1, 32'h0};
    logic [31:0] l[3] = '{32'h0, 32'h0, 32'h0020};
    logic [7:0]  x[3] = '{8'ha0, 8'h88, 8'h82};
    for (int i = 0; i < 3; i++) begin
      wr(REG_FAULT, f[i]);
      wr(REG_LOCK, l[i]);
      erase(23'h028000);
      idle_wait;
      st({x[i], 8'h01});
      wr(REG_FAULT, 32'h0);
      wr(REG_LOCK, 32'h0);
      if (i > 0) begin
        erase(23'h030000);
        st({x[i], 8'h01});
      end
      op(23'h0, CMD_CLEAR);
      st(16'h8001);
    end
  endtask
  task automatic t_susp;
    erase(23'h010000);
    op(23'h010000, CMD_SUSPEND);
    st(16'hc008);
    op(23'h010000, CMD_STATUS);
    rd(REG_DATA);
    chk("susp_status", 32'hc0, q);
    op(23'h020000, CMD_READ);
    rd(REG_DATA);
    chk("susp_read", 32'hffff, q);
    op(23'h010000, CMD_STATUS);
    rd(REG_DATA);
    chk("back_status", 32'hc0, q);
    op(23'h020000, CMD_PROG_SETUP);
    op(23'h020000, 16'h1234);
    idle_wait;
    st(16'hc008);
    op(23'h010001, CMD_PROG_SETUP);
    op(23'h010001, 16'h0000);
    st(16'hd008);
    op(23'h0, CMD_CLEAR);
    op(23'h0, CMD_CONFIRM);
    st(16'h0004);
    idle_wait;
    st(16'h8001);
  endtask
  // program outside a suspend, and a read-mode request refused while erasing
  task automatic t_prog;
    erase(23'h038000);
    op(23'h038000, CMD_READ);
    rd(REG_DATA);
    chk("busy_status", 32'h00, q);
    idle_wait;
    wr(REG_LOCK, 32'h0001);
    op(23'h000010, CMD_PROG_SETUP);
    op(23'h000010, 16'h1234);
    st(16'h9201);
    op(23'h0, CMD_CLEAR);
    wr(REG_LOCK, 32'h0);
    op(23'h000010, CMD_PROG_SETUP);
    op(23'h000010, 16'h1234);
    st(16'h0040);
    idle_wait;
    st(16'h8001);
  endtask
  task automatic t_otp;
    logic [22:0] a[5] = '{23'h85, 23'h82, 23'h90, 23'h86, 23'h87};
    logic [31:0] f[5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h4};
    logic [7:0]  x[5] = '{8'h80, 8'h92, 8'h90, 8'h98, 8'h90};
    for (int i = 0; i < 5; i++) begin
      wr(REG_FAULT, f[i]);
      op(a[i], CMD_PR_SETUP);
      op(a[i], 16'h00f0);
      idle_wait;
      st({x[i], 8'h01});
      op(23'h0, CMD_CLEAR);
    end
    wr(REG_FAULT, 32'h0);
    op(23'h85, CMD_READ);
    rd(REG_DATA);
    chk("otp_word", 32'h00f0, q);
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_erase;
    t_seq;
    t_fault;
    t_susp;
    t_prog;
    t_otp;
    test_done;
  end
  // whole run is several hundred cycles
  initial begin
    repeat (30000) @(posedge hclk);
    err_total++;
    test_done;
  end
endmodule
